/* File: bench/pmicrg_host.sv */
// AXI4-Lite host model for the register bank.
// Assumes one shared clock; the bench calls its tasks.
`default_nettype none
module pmicrg_host (
  // Clock
  input wire logic clk_in,
  // Write channels
  output logic [7:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic [1:0] bresp_in,
  input wire logic bvalid_in,
  output logic bready_out,
  // Read channels
  output logic [7:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out,
    araddr_out, arvalid_out, rready_out} = '0;
  // ****
  // Bus cycles
  // ****
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    wstrb_out <= 4'hf;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awready_in) awvalid_out <= 1'b0;
      if (wready_in) wvalid_out <= 1'b0;
    end while (!bvalid_in);
    r = bresp_in;
    bready_out <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arready_in) arvalid_out <= 1'b0;
    end while (!rvalid_in);
    d = rdata_in;
    r = rresp_in;
    rready_out <= 1'b0;
  endtask : rd
endmodule : pmicrg_host
`default_nettype wire

/* File: bench/pmicrg_regs_chk.sv */
// Port checks on the register bank.
// Assumes one clock and the active-low power-on reset.
`default_nettype none
module pmicrg_regs_chk (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Bus handshakes
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Pins and outputs
  input wire logic system_reset_line_n_in,
  input wire logic restart_request_out,
  input wire logic [1:0] standby_delay_select_out,
  input wire logic alarm_event_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  bvalid_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
  rvalid_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer dropped");
  ar_block_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read taken while busy");
  aw_block_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write taken while busy");
  read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
    s_axi_rvalid_out && s_axi_rdata_out[31:24] == 8'h0) else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out |->
    ##[1:4] s_axi_bvalid_out) else $error("write answer late");
  restart_after_a: assert property (
    restart_request_out |-> $past(system_reset_line_n_in, 2)) else $error("stray restart");
  alarm_pulse_a: assert property (
    alarm_event_out |=> !alarm_event_out) else $error("alarm pulse too long");
  delay_reset_a: assert property (
    !system_reset_line_n_in [*5] |-> standby_delay_select_out == 2'h1)
    else $error("delay field not reset");
  cover property (restart_request_out);
  cover property (alarm_event_out);
  cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);
endmodule : pmicrg_regs_chk
bind pmicrg_regs pmicrg_regs_chk pmicrg_regs_chk_inst (.*);
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the register bank.
// Assumes short tick and second counts set below.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmicrg_pkg::*;
  localparam int TK = 4;
  localparam int SC = 20;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] btn_n = 3'h7;
  logic sb = 1'b0, sb2 = 1'b0, wd_n = 1'b1, sr_n = 1'b1;
  logic [7:0] awa, ara;
  logic [31:0] wdt, rdt;
  logic [3:0] wsb;
  logic [1:0] brs, rrs, spd, ckd, dly;
  logic awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd, req, rsq, sa, ssa, al;
  int n_mismatch = 0, checks_done = 0, cyc = 0, n_rs = 0, n_al = 0;
  logic [31:0] seed = 32'h22a2;
  logic [7:0] ad [9] = '{8'h3c, 8'h40, 8'h44, 8'h48, 8'h4c, 8'h50, 8'h54, 8'h58, 8'h3e};
  logic [23:0] rv0 [7] = '{RST_POWER_CONTROL, 0, 0, 0, 0, 0, RST_CLOCK_TIME_ALARM};
  logic [23:0] msk [7] = '{MASK_POWER_CONTROL, 0, 0, '1, '1, '1, '1};
  logic [23:0] m [7];
  int dn [4] = '{1, 30, 100, 500};
  pmicrg_regs #(.TICK_CYCLES_P(TK), .SECOND_CYCLES_P(SC)) pmicrg_regs_inst (
    .clk_sys_in, .rst_n_in, .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wdt), .s_axi_wstrb_in(wsb), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrd), .s_axi_bresp_out(brs), .s_axi_bvalid_out(bv), .s_axi_bready_in(brd),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdt), .s_axi_rresp_out(rrs), .s_axi_rvalid_out(rv), .s_axi_rready_in(rrd),
    .power_button_first_n_in(btn_n[0]), .power_button_second_n_in(btn_n[1]),
    .power_button_third_n_in(btn_n[2]), .standby_in(sb), .secondary_standby_input_in(sb2),
    .watchdog_input_n_in(wd_n), .system_reset_line_n_in(sr_n), .system_reset_request_out(req),
    .restart_request_out(rsq), .standby_active_out(sa), .secondary_standby_active_out(ssa),
    .serial_port_drive_strength_out(spd), .slow_clock_drive_strength_out(ckd),
    .standby_delay_select_out(dly), .alarm_event_out(al));
  pmicrg_host pmicrg_host_inst (.clk_in(clk_sys_in), .awaddr_out(awa), .awvalid_out(awv),
    .awready_in(awr), .wdata_out(wdt), .wstrb_out(wsb), .wvalid_out(wv), .wready_in(wrd),
    .bresp_in(brs), .bvalid_in(bv), .bready_out(brd), .araddr_out(ara), .arvalid_out(arv),
    .arready_in(arr), .rdata_in(rdt), .rresp_in(rrs), .rvalid_in(rv), .rready_out(rrd));
  initial forever #12.5 clk_sys_in = ~clk_sys_in;
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic int idx(input logic [7:0] a);
    return (a[1:0] == 2'h0 && a >= 8'h3c && a <= 8'h54) ? int'(a - 8'h3c) / 4 : -1;
  endfunction : idx
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : wt
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    int i;
    i = idx(a);
    pmicrg_host_inst.wr(a, d, r);
    chk({30'h0, r}, {30'h0, i < 0 ? RESP_SLVERR : RESP_OKAY});
    if (i >= 0) m[i] = d[23:0] & msk[i];
  endtask : w
  task automatic rchk(input logic [7:0] a);
    logic [1:0] r;
    logic [31:0] d;
    int i;
    i = idx(a);
    pmicrg_host_inst.rd(a, d, r);
    chk({30'h0, r}, {30'h0, i < 0 ? RESP_SLVERR : RESP_OKAY});
    chk(d, i < 0 ? 32'h0 : {8'h0, m[i]});
  endtask : rchk
  task automatic sysrst();
    @(posedge clk_sys_in);
    sr_n <= 1'b0;
    wt(6);
    sr_n <= 1'b1;
    wt(12);
  endtask : sysrst
  always @(posedge clk_sys_in) begin
    cyc++;
    n_rs += int'(rsq);
    n_al += int'(al);
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    int t;
    foreach (m[i]) m[i] = rv0[i];
    wt(10);
    rst_n_in <= 1'b1;
    rchk(8'h50);
    rchk(8'h54);
    w(8'h54, 32'h81ffff);
    w(8'h50, 32'h0);
    for (int k = 0; k < 36; k++) begin
      v = xs();
      w(ad[k % 9], k % 9 == 6 ? v | 32'h800000 : v);
      rchk(ad[k % 9]);
    end
    chk({ckd, spd, dly}, {m[0][18:17], m[0][14:13], m[0][23:22]});
    $display("test registers done");
    w(8'h3c, 32'hffffff);
    w(8'h48, xs());
    t = n_rs;
    sysrst();
    m[0] = (m[0] & ~24'hc01000) | 24'h400000;
    rchk(8'h3c);
    rchk(8'h48);
    chk(n_rs - t, 1);
    w(8'h3c, 32'h0);
    t = n_rs;
    sysrst();
    m[0] = 24'h400000;
    chk(n_rs - t, 0);
    $display("test system reset done");
    for (int i = 0; i < 3; i++) begin
      for (int en = 0; en < 2; en++) begin
        w(8'h3c, en << (i + 1));
        btn_n[i] <= 1'b0;
        wt(30);
        chk(req, en);
        btn_n[i] <= 1'b1;
        wt(30);
        chk(req, 0);
      end
      w(8'h3c, (1 << (i + 1)) | ((i + 1) << (4 + 2 * i)));
      btn_n[i] <= 1'b0;
      wt((dn[i + 1] - 2) * TK);
      chk(req, 0);
      wt(3 * TK + 8);
      chk(req, 1);
      btn_n[i] <= 1'b1;
      wt((dn[i + 1] + 2) * TK + 8);
    end
    w(8'h3c, 32'h1000);
    wd_n <= 1'b0;
    wt(5);
    chk(req, 1);
    wd_n <= 1'b1;
    $display("test buttons done");
    for (int k = 0; k < 8; k++) begin
      v = xs();
      w(8'h3c, {k[1:0], 10'h0});
      sb <= v[0];
      sb2 <= v[1];
      wt(4);
      chk(sa, v[0] ^ k[0]);
      chk(ssa, v[1] ^ k[1]);
    end
    w(8'h50, 32'h3);
    t = n_al;
    w(8'h54, 32'h5);
    wt(3 * SC);
    chk(n_al - t, 1);
    w(8'h54, 32'h800005);
    pmicrg_host_inst.rd(8'h50, v, r);
    chk(int'(v[16:0] >= 17'h00005), 1);
    m[5] = v[23:0];
    wt(2 * SC);
    rchk(8'h50);
    $display("test clock done");
    rst_n_in <= 1'b0;
    wt(3);
    rst_n_in <= 1'b1;
    foreach (m[i]) m[i] = rv0[i];
    rchk(8'h48);
    rchk(8'h3c);
    $display("test power-on reset done");
    close_out();
  end
endmodule : tb
`default_nettype wire

/* File: rtl/pmicrg_debounce.sv */
// Debounce filter for one synchronised power-button level.
// Assumes a one-cycle millisecond enable from the parent's divider.
`default_nettype none
module pmicrg_debounce (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Timing and selection
  input wire logic tick_in,
  input wire logic [1:0] select_in,
  // Level in and out
  input wire logic raw_in,
  output logic stable_out
);
  import pmicrg_pkg::*;

  typedef struct packed {
    logic stable;
    logic [DEBOUNCE_W-1:0] count;
  } pmicrg_deb_t;

  pmicrg_deb_t st;
  pmicrg_deb_t next_st;
  logic [DEBOUNCE_W-1:0] limit;

  always_comb begin
    unique case (select_in)
      2'h0: limit = DEBOUNCE_MS_0;
      2'h1: limit = DEBOUNCE_MS_1;
      2'h2: limit = DEBOUNCE_MS_2;
      2'h3: limit = DEBOUNCE_MS_3;
    endcase
  end

  // Level must hold for the selected time before it is accepted
  always_comb begin
    next_st = st;
    if (raw_in == st.stable) begin
      next_st.count = '0;
    end else if (tick_in) begin
      if (st.count + 10'h001 >= limit) begin
        next_st.stable = raw_in;
        next_st.count = '0;
      end else begin
        next_st.count = st.count + 10'h001;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign stable_out = st.stable;
endmodule : pmicrg_debounce
`default_nettype wire

/* File: rtl/pmicrg_pkg.sv */
// Constants shared by the power-control and clock register bank.
// Assumes a 40 MHz system clock and 32-bit register bus words.
`default_nettype none
package pmicrg_pkg;
  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] IDX_POWER_CONTROL_THIRD = 6'h0f;
  localparam logic [5:0] IDX_UNUSED_WORD_A = 6'h10;
  localparam logic [5:0] IDX_UNUSED_WORD_B = 6'h11;
  localparam logic [5:0] IDX_BACKUP_SCRATCH_FIRST = 6'h12;
  localparam logic [5:0] IDX_BACKUP_SCRATCH_SECOND = 6'h13;
  localparam logic [5:0] IDX_CLOCK_TIME_OF_DAY = 6'h14;
  localparam logic [5:0] IDX_CLOCK_TIME_ALARM = 6'h15;
  localparam int ADDR_W = 8;
  localparam int REG_W = 24;

  // ****************************************************************
  // Field positions of the third power-control word
  // ****************************************************************
  localparam int POS_AUTO_RESTART = 0;
  localparam int POS_BUTTON_RESET = 1;
  localparam int POS_DEBOUNCE = 4;
  localparam int POS_STANDBY_INV = 10;
  localparam int POS_STANDBY_SEC_INV = 11;
  localparam int POS_WATCHDOG_RESET = 12;
  localparam int POS_SERIAL_DRIVE = 13;
  localparam int POS_SLOW_CLOCK_DRIVE = 17;
  localparam int POS_STANDBY_DELAY = 22;
  localparam logic [23:0] MASK_POWER_CONTROL = 24'hc67fff;
  localparam logic [23:0] RST_POWER_CONTROL = 24'h400000;
  localparam logic [1:0] RST_STANDBY_DELAY = 2'h1;

  // ****************************************************************
  // Clock word and alarm word layout
  // ****************************************************************
  localparam int TIME_COUNT_W = 17;
  localparam int POS_CALIBRATION_COUNT = 17;
  localparam int POS_CALIBRATION_MODE = 22;
  localparam int POS_CLOCK_DISABLE = 23;
  localparam logic [23:0] RST_CLOCK_TIME_ALARM = 24'h01ffff;
  localparam logic [16:0] TIME_COUNT_LAST = 17'h1517f;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 40;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_US * CLK_MHZ;
  localparam int SECOND_US = 1000000;
  localparam int SECOND_CYCLES = SECOND_US * CLK_MHZ;
  localparam int DEBOUNCE_W = 10;
  localparam logic [DEBOUNCE_W-1:0] DEBOUNCE_MS_0 = 10'h001;
  localparam logic [DEBOUNCE_W-1:0] DEBOUNCE_MS_1 = 10'h01e;
  localparam logic [DEBOUNCE_W-1:0] DEBOUNCE_MS_2 = 10'h064;
  localparam logic [DEBOUNCE_W-1:0] DEBOUNCE_MS_3 = 10'h1f4;

  // ****************************************************************
  // Bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pmicrg_pkg
`default_nettype wire

/* File: rtl/pmicrg_regs.sv */
// Power-control, backup scratch and time-of-day register bank.
// Assumes an AXI4-Lite master on clk_sys_in; pins arrive asynchronously.
//
// What this block does
// - Restart-enable set makes the device restart power-up after a system reset.
// - With its enable set, the first power button causes a system reset.
// - With its enable set, the second power button causes a system reset.
// - With its enable set, the third power button causes a system reset.
// - Each power button is debounced; a two-bit field selects each time.
// - Polarity bit set treats the primary standby input as active low.
// - Polarity bit set treats the secondary standby input as active low.
// - Watchdog reset enable; cleared by system reset and by power-on reset.
// - Two-bit field sets shared slow-clock drive strength; power-on reset clears it.
`default_nettype none
module pmicrg_regs #(
  parameter int TICK_CYCLES_P = pmicrg_pkg::TICK_CYCLES,
  parameter int SECOND_CYCLES_P = pmicrg_pkg::SECOND_CYCLES
) (
  // Clock and backup-domain power-on reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // AXI4-Lite write address and data
  input wire logic [pmicrg_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [pmicrg_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Device pins
  input wire logic power_button_first_n_in,
  input wire logic power_button_second_n_in,
  input wire logic power_button_third_n_in,
  input wire logic standby_in,
  input wire logic secondary_standby_input_in,
  input wire logic watchdog_input_n_in,
  input wire logic system_reset_line_n_in,
  // Control outputs
  output logic system_reset_request_out,
  output logic restart_request_out,
  output logic standby_active_out,
  output logic secondary_standby_active_out,
  output logic [1:0] serial_port_drive_strength_out,
  output logic [1:0] slow_clock_drive_strength_out,
  output logic [1:0] standby_delay_select_out,
  output logic alarm_event_out
);
  import pmicrg_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic reset_line_prev;
    logic restart;
    logic alarm;
    logic [15:0] tick_div;
    logic tick;
    logic [26:0] sec_div;
    logic [23:0] power_control;
    logic [23:0] scratch_first;
    logic [23:0] scratch_second;
    logic [23:0] time_word;
    logic [23:0] alarm_word;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pmicrg_state_t;

  pmicrg_state_t st;
  pmicrg_state_t next_st;
  logic [2:0] pressed;
  logic [2:0] button_enable;
  logic [26:0] sec_limit;
  logic [5:0] w_index;
  logic [5:0] r_index;
  logic w_ok;
  logic r_ok;
  logic [23:0] read_word;

  function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [23:0] mask);
    logic [23:0] bytes;
    bytes = {{8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~(bytes & mask)) | (data[23:0] & bytes & mask);
  endfunction : merge

  // ****************************************************************
  // Button filters
  // ****************************************************************
  assign button_enable = st.power_control[POS_BUTTON_RESET +: 3];

  generate
    for (genvar i = 0; i < 3; i++) begin : g_button
      pmicrg_debounce u_debounce (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .tick_in(st.tick),
        .select_in(st.power_control[POS_DEBOUNCE + 2 * i +: 2]),
        .raw_in(~st.sync2[i]),
        .stable_out(pressed[i])
      );
    end
  endgenerate

  // ****************************************************************
  // Address decode
  // ****************************************************************
  assign w_index = st.aw_addr[7:2];
  assign r_index = s_axi_araddr_in[7:2];
  assign w_ok = (st.aw_addr[1:0] == 2'h0) && (w_index >= IDX_POWER_CONTROL_THIRD) &&
                (w_index <= IDX_CLOCK_TIME_ALARM);
  assign r_ok = (s_axi_araddr_in[1:0] == 2'h0) && (r_index >= IDX_POWER_CONTROL_THIRD) &&
                (r_index <= IDX_CLOCK_TIME_ALARM);

  always_comb begin
    unique case (r_index)
      IDX_POWER_CONTROL_THIRD: read_word = st.power_control;
      IDX_BACKUP_SCRATCH_FIRST: read_word = st.scratch_first;
      IDX_BACKUP_SCRATCH_SECOND: read_word = st.scratch_second;
      IDX_CLOCK_TIME_OF_DAY: read_word = st.time_word;
      IDX_CLOCK_TIME_ALARM: read_word = st.alarm_word;
      default: read_word = 24'h000000;
    endcase
  end

  // Calibration shifts the second period by a signed count
  assign sec_limit = (st.time_word[POS_CALIBRATION_MODE +: 2] == 2'h0) ?
    27'(SECOND_CYCLES_P - 1) :
    27'(SECOND_CYCLES_P - 1 + int'($signed(st.time_word[POS_CALIBRATION_COUNT +: 5])));

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.sync1 = {~system_reset_line_n_in, watchdog_input_n_in, secondary_standby_input_in,
                     standby_in, power_button_third_n_in, power_button_second_n_in,
                     power_button_first_n_in};
    next_st.sync2 = st.sync1;
    next_st.restart = 1'b0;
    next_st.alarm = 1'b0;

    // Millisecond enable for the filters
    next_st.tick = 1'b0;
    if (st.tick_div == 16'(TICK_CYCLES_P - 1)) begin
      next_st.tick_div = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_div = st.tick_div + 16'h0001;
    end

    // Time of day counts seconds while the clock is enabled
    if (!st.alarm_word[POS_CLOCK_DISABLE]) begin
      if (st.sec_div >= sec_limit) begin
        next_st.sec_div = '0;
        if (st.time_word[TIME_COUNT_W-1:0] == TIME_COUNT_LAST) begin
          next_st.time_word[TIME_COUNT_W-1:0] = '0;
        end else begin
          next_st.time_word[TIME_COUNT_W-1:0] = st.time_word[TIME_COUNT_W-1:0] + 17'h00001;
        end
        if (next_st.time_word[TIME_COUNT_W-1:0] == st.alarm_word[TIME_COUNT_W-1:0]) begin
          next_st.alarm = 1'b1;
        end
      end else begin
        next_st.sec_div = st.sec_div + 27'h0000001;
      end
    end

    // Restart after the system reset line is released
    next_st.reset_line_prev = st.sync2[6];
    if (st.reset_line_prev && !st.sync2[6] && st.power_control[POS_AUTO_RESTART]) begin
      next_st.restart = 1'b1;
    end

    // Write channel capture
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      next_st.aw_got = 1'b1;
      next_st.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      next_st.w_got = 1'b1;
      next_st.w_data = s_axi_wdata_in;
      next_st.w_strb = s_axi_wstrb_in;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = w_ok ? RESP_OKAY : RESP_SLVERR;
      // Refused addresses leave every register untouched
      if (w_ok) begin
        unique case (w_index)
          IDX_POWER_CONTROL_THIRD: begin
            next_st.power_control = merge(st.power_control, st.w_data, st.w_strb,
                                          MASK_POWER_CONTROL);
          end
          IDX_BACKUP_SCRATCH_FIRST: begin
            next_st.scratch_first = merge(st.scratch_first, st.w_data, st.w_strb,
                                          24'hffffff);
          end
          IDX_BACKUP_SCRATCH_SECOND: begin
            next_st.scratch_second = merge(st.scratch_second, st.w_data, st.w_strb,
                                           24'hffffff);
          end
          IDX_CLOCK_TIME_OF_DAY: begin
            next_st.time_word = merge(st.time_word, st.w_data, st.w_strb, 24'hffffff);
            next_st.sec_div = '0;
          end
          IDX_CLOCK_TIME_ALARM: begin
            next_st.alarm_word = merge(st.alarm_word, st.w_data, st.w_strb, 24'hffffff);
          end
          default: begin
          end
        endcase
      end
    end else if (st.bvalid && s_axi_bready_in) begin
      next_st.bvalid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = r_ok ? {8'h00, read_word} : 32'h00000000;
      next_st.rresp = r_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && s_axi_rready_in) begin
      next_st.rvalid = 1'b0;
    end

    // System reset clears the watchdog enable and reloads the delay field; scratch words stay
    if (st.sync2[6]) begin
      next_st.power_control[POS_WATCHDOG_RESET] = 1'b0;
      next_st.power_control[POS_STANDBY_DELAY +: 2] = RST_STANDBY_DELAY;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.sync1 <= 7'h27;
      st.sync2 <= 7'h27;
      st.power_control <= RST_POWER_CONTROL;
      st.alarm_word <= RST_CLOCK_TIME_ALARM;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready_out = !st.aw_got && !st.bvalid;
  assign s_axi_wready_out = !st.w_got && !st.bvalid;
  assign s_axi_bvalid_out = st.bvalid;
  assign s_axi_bresp_out = st.bresp;
  assign s_axi_arready_out = !st.rvalid;
  assign s_axi_rvalid_out = st.rvalid;
  assign s_axi_rdata_out = st.rdata;
  assign s_axi_rresp_out = st.rresp;

  assign system_reset_request_out = |(pressed & button_enable) |
    (st.power_control[POS_WATCHDOG_RESET] && !st.sync2[5]);
  assign restart_request_out = st.restart;
  assign standby_active_out = st.sync2[3] ^ st.power_control[POS_STANDBY_INV];
  assign secondary_standby_active_out =
    st.sync2[4] ^ st.power_control[POS_STANDBY_SEC_INV];
  assign serial_port_drive_strength_out = st.power_control[POS_SERIAL_DRIVE +: 2];
  assign slow_clock_drive_strength_out = st.power_control[POS_SLOW_CLOCK_DRIVE +: 2];
  assign standby_delay_select_out = st.power_control[POS_STANDBY_DELAY +: 2];
  assign alarm_event_out = st.alarm;
endmodule : pmicrg_regs
`default_nettype wire
